/* File: src/ufic_pkg.sv */
// constants shared by the frame index and configure flag block
// assumes a 20 MHz pclk and an APB master with 32-bit data
package ufic_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned UFRAME_US = 125;
    localparam int unsigned UFRAME_CYCLES = CLK_HZ / 1_000_000 * UFRAME_US;

    localparam int ADDR_W = 12;
    localparam int IDX_W = 14;
    localparam int LIST_W = 10;
    localparam int LIST_LSB = 3;

    localparam logic [11:0] OFS_STATUS = 12'h024;
    localparam logic [11:0] OFS_INDEX = 12'h02c;
    localparam logic [11:0] OFS_CONFIG = 12'h060;
    localparam logic [11:0] OFS_MASK = 12'h070;

    localparam int ROLL_BIT = 3;
    localparam int CFG_DONE_BIT = 0;
    localparam logic [31:0] STATUS_RST = 32'h0000_0000;
    localparam logic [31:0] MASK_RST = 32'h0000_0000;
    localparam logic [13:0] INDEX_RST = 14'h0000;
    localparam logic [31:0] STATUS_USED = 32'h0000_0008;

    typedef enum logic [1:0] {
        UFIC_LIST_1024 = 2'b00,
        UFIC_LIST_512 = 2'b01,
        UFIC_LIST_256 = 2'b10,
        UFIC_LIST_RSVD = 2'b11
    } ufic_list_size_t;

    // frame index bits that take part in the list index
    function automatic logic [13:0] ufic_list_mask(input logic [1:0] size);
        unique case (ufic_list_size_t'(size))
            UFIC_LIST_512: ufic_list_mask = 14'h0fff;
            UFIC_LIST_256: ufic_list_mask = 14'h07ff;
            default: ufic_list_mask = 14'h1fff;
        endcase
    endfunction
endpackage

/* File: src/ufic_tick_if.sv */
// microframe timing link between the timer and the register core
// assumes both ends run on pclk
`timescale 1ns/1ps
`default_nettype none
interface ufic_tick_if;
    logic run;
    logic tick;
    modport timer (input run, output tick);
    modport core (output run, input tick);
endinterface
`default_nettype wire

/* File: src/ufic_uframe_timer.sv */
// microframe timer: one tick per microframe while running
// assumes run comes from pclk-domain logic
`timescale 1ns/1ps
`default_nettype none
module ufic_uframe_timer #(
    parameter int unsigned CYCLES = ufic_pkg::UFRAME_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // link to the core
    ufic_tick_if.timer tk
);
    localparam logic [15:0] LAST = 16'(CYCLES - 1);
    logic [15:0] count_ff;

    if (CYCLES < 2 || CYCLES > 65536) begin : bad_cycles
        $error("microframe cycle count out of range");
    end

    // stopped timer restarts a full microframe on the next run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_ff <= 16'h0000;
        end else if (!tk.run || count_ff == LAST) begin
            count_ff <= 16'h0000;
        end else begin
            count_ff <= count_ff + 16'h0001;
        end
    end

    assign tk.tick = tk.run && count_ff == LAST;

    tick_period_a: assert property (@(posedge pclk) disable iff (!presetn)
        tk.tick |=> !tk.tick [*8])
        else $error("microframe ticks too close");
    tick_count_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(tk.run) |=> (count_ff == 16'h0001 || !tk.run))
        else $error("timer did not restart on run");
endmodule // ufic_uframe_timer
`default_nettype wire

/* File: src/ufic_frame_index.sv */
// frame index counter, configure flag, rollover status and port owners
// assumes run and list size come from the command logic on pclk
`timescale 1ns/1ps
`default_nettype none
module ufic_frame_index #(
    parameter int PORTS = 3,
    parameter int unsigned UFRAME_CYCLES = ufic_pkg::UFRAME_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ufic_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // command logic
    input wire logic run_stop,
    input wire logic [1:0] list_size_field,
    // schedule and packet logic
    output logic [ufic_pkg::IDX_W-1:0] sof_frame_number,
    output logic [ufic_pkg::LIST_W-1:0] list_index,
    output logic uframe_tick,
    // port routing
    output logic configured_bit,
    output logic [PORTS-1:0] port_owner_bit,
    // status
    output logic rollover_flag,
    output logic irq
);
    if (PORTS < 1 || PORTS > 15) begin : bad_ports
        $error("PORTS must be 1 to 15");
    end

    ufic_tick_if tk ();

    ufic_uframe_timer #(.CYCLES(UFRAME_CYCLES)) u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .tk(tk.timer)
    );

    localparam int LIST_W = ufic_pkg::LIST_W;
    localparam int IDX_W = ufic_pkg::IDX_W;

    logic [IDX_W-1:0] uidx_ff;
    logic [31:0] status_ff;
    logic [31:0] mask_ff;
    logic cfg_done_ff;
    logic cfg_prev_ff;
    logic [PORTS-1:0] owner_ff;
    logic [31:0] prdata_ff;
    logic setup;
    logic access;
    logic hit;
    logic wr_index;
    logic wr_config;
    logic wr_mask;
    logic rd_status;
    logic [IDX_W-1:0] lmask;
    logic wrap;
    logic [31:0] nxt_rdata;

    assign tk.run = run_stop;
    assign uframe_tick = tk.tick;

    function automatic logic is_reg(input logic [11:0] a);
        is_reg = a == ufic_pkg::OFS_STATUS || a == ufic_pkg::OFS_INDEX ||
                 a == ufic_pkg::OFS_CONFIG || a == ufic_pkg::OFS_MASK;
    endfunction

    assign setup = psel && !penable;
    assign access = psel && penable;
    assign hit = is_reg(paddr);
    assign wr_index = access && pwrite && paddr == ufic_pkg::OFS_INDEX;
    assign wr_config = access && pwrite && paddr == ufic_pkg::OFS_CONFIG;
    assign wr_mask = access && pwrite && paddr == ufic_pkg::OFS_MASK;
    assign rd_status = access && !pwrite && paddr == ufic_pkg::OFS_STATUS;

    assign lmask = ufic_pkg::ufic_list_mask(list_size_field);
    assign wrap = tk.tick && (uidx_ff & lmask) == lmask;

    // zero wait states; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = access && !hit;
    assign prdata = prdata_ff;

    // a software write wins over a tick in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            uidx_ff <= ufic_pkg::INDEX_RST;
        end else if (wr_index) begin
            uidx_ff <= pwdata[IDX_W-1:0];
        end else if (tk.tick) begin
            uidx_ff <= uidx_ff + 14'h0001;
        end
    end

    assign sof_frame_number = uidx_ff;
    assign list_index = LIST_W'((uidx_ff & lmask) >> ufic_pkg::LIST_LSB);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_done_ff <= 1'b0;
            cfg_prev_ff <= 1'b0;
        end else begin
            if (wr_config) begin
                cfg_done_ff <= pwdata[ufic_pkg::CFG_DONE_BIT];
            end
            cfg_prev_ff <= cfg_done_ff;
        end
    end

    assign configured_bit = cfg_done_ff;

    // owners stay with the companion until configured
    // a cleared flag reaches the owners one cycle late
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            owner_ff <= '1;
        end else if (!cfg_done_ff) begin
            owner_ff <= '1;
        end else if (!cfg_prev_ff) begin
            owner_ff <= '0;
        end
    end

    assign port_owner_bit = owner_ff;

    // a read clears only what it returned, so a new rollover survives
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_ff <= ufic_pkg::STATUS_RST;
        end else begin
            status_ff[ufic_pkg::ROLL_BIT] <= wrap ||
                (status_ff[ufic_pkg::ROLL_BIT] &&
                 !(rd_status && prdata_ff[ufic_pkg::ROLL_BIT]));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_ff <= ufic_pkg::MASK_RST;
        end else if (wr_mask) begin
            mask_ff <= pwdata & ufic_pkg::STATUS_USED;
        end
    end

    assign rollover_flag = status_ff[ufic_pkg::ROLL_BIT];
    assign irq = |(status_ff & mask_ff);

    always_comb begin
        nxt_rdata = 32'h0000_0000;
        unique case (paddr)
            ufic_pkg::OFS_STATUS: nxt_rdata = status_ff;
            ufic_pkg::OFS_INDEX: nxt_rdata = 32'(uidx_ff);
            ufic_pkg::OFS_CONFIG: nxt_rdata = 32'(cfg_done_ff);
            ufic_pkg::OFS_MASK: nxt_rdata = mask_ff;
            default: nxt_rdata = 32'h0000_0000;
        endcase
    end

    // read data captured in the setup cycle, held through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata_ff <= nxt_rdata;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // checks stated per bit, not copied from the expressions above
    index_advance_a: assert property (tk.tick && !wr_index |=>
        uidx_ff == $past(uidx_ff) + 14'h0001)
        else $error("frame index did not advance on tick");
    index_hold_a: assert property (!run_stop && !wr_index |=>
        uidx_ff == $past(uidx_ff))
        else $error("frame index moved while stopped");
    stop_no_tick_a: assert property (!run_stop |-> !uframe_tick)
        else $error("microframe tick while stopped");
    index_write_a: assert property (wr_index |=>
        sof_frame_number == $past(pwdata[IDX_W-1:0]))
        else $error("written index not in frame number");
    list_index_a: assert property (
        list_index[7:0] == uidx_ff[ufic_pkg::LIST_LSB +: 8] &&
        list_index[LIST_W-2] == (uidx_ff[ufic_pkg::LIST_LSB + 8] &&
            list_size_field != ufic_pkg::UFIC_LIST_256) &&
        list_index[LIST_W-1] == (uidx_ff[ufic_pkg::LIST_LSB + 9] &&
            (list_size_field == ufic_pkg::UFIC_LIST_1024 ||
             list_size_field == ufic_pkg::UFIC_LIST_RSVD)))
        else $error("list index mismatch");
    rollover_set_a: assert property (wrap |=> rollover_flag)
        else $error("rollover flag not set on wrap");
    rollover_hold_a: assert property (rollover_flag && !rd_status |=> rollover_flag)
        else $error("rollover flag lost without a read");
    status_clear_a: assert property (rd_status && prdata_ff[ufic_pkg::ROLL_BIT] && !wrap |=>
        !rollover_flag)
        else $error("rollover flag not cleared by read");
    config_write_a: assert property (wr_config |=>
        configured_bit == $past(pwdata[ufic_pkg::CFG_DONE_BIT]))
        else $error("configured bit not written");
    owner_unconf_a: assert property (!cfg_done_ff |=> &owner_ff)
        else $error("port owner not held while unconfigured");
    owner_clear_a: assert property ($rose(cfg_done_ff) |=> owner_ff == '0 && configured_bit)
        else $error("port owner not cleared on configure");
    wrap_to_zero_a: assert property (tk.tick && !wr_index &&
        uidx_ff == 14'h3fff |=> uidx_ff == 14'h0000)
        else $error("frame index did not wrap");
    irq_level_a: assert property (irq == (rollover_flag && mask_ff[ufic_pkg::ROLL_BIT]))
        else $error("interrupt does not follow status");

    tick_seen_c: cover property (tk.tick);
    rollover_c: cover property (wrap ##1 rd_status);
    configure_c: cover property ($rose(cfg_done_ff));
    unconfigure_c: cover property ($fell(cfg_done_ff));
    write_index_c: cover property (wr_index ##1 tk.tick);
endmodule // ufic_frame_index
`default_nettype wire

/* File: dv/ufic_cmd_model.sv */
// command logic stand-in: run/stop bit and list size for the index block
// assumes the bench sets cmd_run and cmd_size right after a pclk rising edge
`timescale 1ns/1ps
`default_nettype none
module ufic_cmd_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench request
    input wire logic cmd_run,
    input wire logic [1:0] cmd_size,
    // to the block
    output logic run_stop,
    output logic [1:0] list_size_field
);
    // registered, so changes land one edge late like a real command register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_stop <= 1'b0;
            list_size_field <= 2'h0;
        end else begin
            run_stop <= cmd_run;
            list_size_field <= cmd_size;
        end
    end
endmodule // ufic_cmd_model
`default_nettype wire

/* File: dv/tb_top.sv */
// self-checking bench for the frame index and configure flag block
// assumes a 20 MHz pclk; microframe shortened to 20 cycles
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, cmd_run;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, run_stop, uframe_tick, configured_bit, rollover_flag, irq;
    logic [1:0] cmd_size, list_size_field;
    logic [13:0] sof_frame_number, r;
    logic [9:0] list_index;
    logic [2:0] port_owner_bit;
    logic [31:0] exp_q[$];
    int bad_count, samples_checked, n;

    ufic_cmd_model cmd (.pclk(pclk), .presetn(presetn), .cmd_run(cmd_run),
        .cmd_size(cmd_size), .run_stop(run_stop), .list_size_field(list_size_field));
    ufic_frame_index #(.PORTS(3), .UFRAME_CYCLES(20)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .run_stop(run_stop),
        .list_size_field(list_size_field), .sof_frame_number(sof_frame_number),
        .list_index(list_index), .uframe_tick(uframe_tick), .configured_bit(configured_bit),
        .port_owner_bit(port_owner_bit), .rollover_flag(rollover_flag), .irq(irq));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    function automatic logic [13:0] msk(input int s);
        return (s == 1) ? 14'h0fff : (s == 2) ? 14'h07ff : 14'h1fff;
    endfunction

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic wait_tick();
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (uframe_tick !== 1'b1 && n < 200);
    endtask

    // result watcher: every completed transfer, read data against the oldest note
    always @(posedge pclk) begin
        if (psel && penable) begin
            chk(32'(pready), 32'h1);
            if (pready) begin
                chk(32'(pslverr), 32'(!(paddr inside {12'h024, 12'h02c, 12'h060, 12'h070})));
                if (!pwrite) chk(prdata, exp_q.pop_front());
            end
        end
    end

    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        end_of_test();
    end

    initial begin
        void'($urandom(2242));
        {presetn, psel, penable, pwrite, cmd_run} = 5'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        cmd_size = 2'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk(32'(port_owner_bit), 32'h7);
        rd(12'h02c, 32'h0);
        rd(12'h060, 32'h0);
        rd(12'h024, 32'h0);
        // full-word writes, reserved bits zero, only while stopped
        for (int s = 0; s < 4; s++) begin
            r = 14'($urandom);
            cmd_size <= 2'(s);
            apb(1'b1, 12'h02c, {18'h0, r});
            @(negedge pclk);
            chk(32'(sof_frame_number), 32'(r));
            chk(32'(list_index), 32'((r & msk(s)) >> 3));
            rd(12'h02c, {18'h0, r});
        end
        apb(1'b1, 12'h070, 32'h8);
        for (int k = 0; k < 2; k++) begin
            r = k ? 14'h3fff : 14'h07ff;
            cmd_size <= k ? 2'h0 : 2'h2;
            apb(1'b1, 12'h02c, {18'h0, r});
            cmd_run <= 1'b1;
            wait_tick();
            @(negedge pclk);
            chk(32'(sof_frame_number), 32'(14'(r + 14'h1)));
            chk(32'({rollover_flag, irq}), 32'h3);
            wait_tick();
            // one negedge was spent above, so the gap reads one short
            chk(n, 19);
            @(posedge pclk);
            cmd_run <= 1'b0;
            rd(12'h024, 32'h8);
            @(negedge pclk);
            chk(32'({rollover_flag, irq}), 32'h0);
            repeat (60) @(negedge pclk);
            chk(32'(sof_frame_number), 32'(14'(r + 14'h2)));
        end
        apb(1'b1, 12'h060, 32'h1);
        repeat (2) @(negedge pclk);
        chk(32'({configured_bit, port_owner_bit}), 32'h8);
        rd(12'h060, 32'h1);
        apb(1'b1, 12'h060, 32'h0);
        repeat (2) @(negedge pclk);
        chk(32'(port_owner_bit), 32'h7);
        apb(1'b1, 12'h044, 32'h5);
        rd(12'h044, 32'h0);
        repeat (3) @(posedge pclk);
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
